// *** shared/smcd_pkg.sv ***
// Purpose: constants for the supervisor and memory configuration decoder
// Assumes: 14-bit configuration words, 32-bit AXI4-Lite register bus
// Notes:   word addresses are program-space locations of the two words
package smcd_pkg;
	// ****************************************
	// configuration word locations
	// ****************************************
	localparam logic [15:0] SMCD_SUP_WORD_ADDR = 16'h8008;
	localparam logic [15:0] SMCD_MEM_WORD_ADDR = 16'h8009;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] SMCD_OFF_SUP    = 8'h00;
	localparam logic [7:0] SMCD_OFF_MEM    = 8'h04;
	localparam logic [7:0] SMCD_OFF_CTRL   = 8'h08;
	localparam logic [7:0] SMCD_OFF_STATUS = 8'h0C;
	localparam logic [7:0] SMCD_OFF_PROG   = 8'h10;
	// ****************************************
	// supervisor and memory word fields
	// ****************************************
	localparam int SMCD_B_DEBUG   = 13;
	localparam int SMCD_B_STKRST  = 12;
	localparam int SMCD_B_ONEWAY  = 11;
	localparam int SMCD_B_BORLVL  = 9;
	localparam int SMCD_B_BROWNOUT_ENABLE_FIELD   = 6;
	localparam int SMCD_B_LPBOR   = 5;
	localparam int SMCD_B_WATCHDOG_ENABLE_FIELD    = 2;
	localparam int SMCD_B_POWER_UP_DELAY_TIMER    = 1;
	localparam int SMCD_B_RSTPIN  = 0;
	localparam int SMCD_B_LVP     = 13;
	localparam int SMCD_B_WRT     = 0;
	localparam logic [13:0] SMCD_SUP_IMPL = 14'h3AEF;
	localparam logic [13:0] SMCD_MEM_IMPL = 14'h2003;
	localparam logic [13:0] SMCD_WORD_RST = 14'h3FFF;
	// ****************************************
	// encodings
	// ****************************************
	localparam logic [1:0] SMCD_BOR_ON    = 2'h3;
	localparam logic [1:0] SMCD_BOR_SLEEP = 2'h2;
	localparam logic [1:0] SMCD_BOR_SW    = 2'h1;
	localparam logic [1:0] SMCD_WDT_ON    = 2'h3;
	localparam logic [1:0] SMCD_WRT_OFF   = 2'h3;
	localparam logic [1:0] SMCD_WRT_BOOT  = 2'h2;
	localparam logic [1:0] SMCD_WRT_HALF  = 2'h1;
	localparam logic [13:0] SMCD_BOOT_TOP = 14'h01FF;
	localparam logic [13:0] SMCD_HALF_TOP = 14'h1FFF;
	localparam logic [4:0] SMCD_STACK_FULL = 5'h0F;
	localparam logic [4:0] SMCD_STACK_EMPTY = 5'h1F;
	localparam logic [1:0] SMCD_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SMCD_RESP_SLVERR = 2'h2;
	// unlock sequence bytes, arbitrary values
	localparam logic [7:0] SMCD_UNLOCK_1 = 8'h55;
	localparam logic [7:0] SMCD_UNLOCK_2 = 8'hAA;
endpackage

// *** src/smcd_top.sv ***
// Purpose: decodes supervisor and memory configuration words into controls
// Assumes: words are sampled while rst_b is low, registers over AXI4-Lite
// Notes:   all outputs are registered
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module smcd_top (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [13:0] nvm_sup_word,
	input  wire logic [13:0] nvm_mem_word,
	input  wire logic        core_sleep,
	input  wire logic        stack_push,
	input  wire logic        stack_pop,
	input  wire logic [4:0]  stack_ptr,
	input  wire logic        self_wr_req,
	input  wire logic        ext_wr_req,
	input  wire logic [13:0] wr_addr,
	input  wire logic        lvp_entry,
	input  wire logic        prog_wr_req,
	input  wire logic [15:0] prog_addr,
	input  wire logic [13:0] prog_data,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             stack_reset_r,
	output logic             bor_active_r,
	output logic             bor_level_low_r,
	output logic             lp_bor_en_r,
	output logic             wdt_en_r,
	output logic             power_up_delay_timer_en_r,
	output logic             pin_is_reset_r,
	output logic             lvp_allowed_r,
	output logic             debug_active_r,
	output logic             pin_map_locked_r,
	output logic             wr_grant_r,
	output logic             wr_block_r,
	output logic             prog_refused_r
);
	import smcd_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic wrt_blocks(input logic [1:0] f, input logic [13:0] a);
		logic b;
		b = 1'b1;
		if (f == SMCD_WRT_OFF) begin
			b = 1'b0;
		end else if (f == SMCD_WRT_BOOT) begin
			b = (a <= SMCD_BOOT_TOP);
		end else if (f == SMCD_WRT_HALF) begin
			b = (a <= SMCD_HALF_TOP);
		end
		return b;
	endfunction

	// ****************************************
	// configuration capture
	// ****************************************
	logic [13:0] sup_r;
	logic [13:0] mem_r;
	logic        sw_bor_r;
	logic        lock_used_r;
	logic [1:0]  unlock_st_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;

	// programming path rewrites the words while running; a capture in reset wins over it
	wire prog_sup = prog_wr_req && (prog_addr == SMCD_SUP_WORD_ADDR);
	wire prog_mem = prog_wr_req && (prog_addr == SMCD_MEM_WORD_ADDR);
	wire lvp_clear = prog_mem && lvp_entry && !prog_data[SMCD_B_LVP];
	wire [13:0] mem_prog = lvp_clear ? (prog_data | 14'h2000) : prog_data;
	wire [13:0] sup_nxt = !rst_b ? (nvm_sup_word | ~SMCD_SUP_IMPL)
		: prog_sup ? (prog_data | ~SMCD_SUP_IMPL) : sup_r;
	wire [13:0] mem_nxt = !rst_b ? (nvm_mem_word | ~SMCD_MEM_IMPL)
		: prog_mem ? (mem_prog | ~SMCD_MEM_IMPL) : mem_r;

	always_ff @(posedge clock) begin
		sup_r <= sup_nxt;
		mem_r <= mem_nxt;
	end

	// ****************************************
	// field decode
	// ****************************************
	wire [1:0] bor_f  = sup_r[SMCD_B_BROWNOUT_ENABLE_FIELD +: 2];
	wire [1:0] wdt_f  = sup_r[SMCD_B_WATCHDOG_ENABLE_FIELD +: 2];
	wire [1:0] wrt_f  = mem_r[SMCD_B_WRT +: 2];
	wire       lvp_on = mem_r[SMCD_B_LVP];
	wire bor_nxt = (bor_f == SMCD_BOR_ON) ? 1'b1
		: (bor_f == SMCD_BOR_SLEEP) ? !core_sleep
		: (bor_f == SMCD_BOR_SW) ? sw_bor_r : 1'b0;
	wire overflow  = stack_push && (stack_ptr == SMCD_STACK_FULL);
	wire underflow = stack_pop && (stack_ptr == SMCD_STACK_EMPTY);
	wire stk_nxt = sup_r[SMCD_B_STKRST] && (overflow || underflow);
	wire pin_nxt = lvp_on || sup_r[SMCD_B_RSTPIN];
	wire blk_nxt = self_wr_req && wrt_blocks(wrt_f, wr_addr);
	wire gnt_nxt = ext_wr_req || (self_wr_req && !blk_nxt);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stack_reset_r   <= 1'b0;
			bor_active_r    <= 1'b0;
			bor_level_low_r <= 1'b0;
			lp_bor_en_r     <= 1'b0;
			wdt_en_r        <= 1'b0;
			power_up_delay_timer_en_r       <= 1'b0;
			pin_is_reset_r  <= 1'b1;
			lvp_allowed_r   <= 1'b0;
			debug_active_r  <= 1'b0;
			wr_grant_r      <= 1'b0;
			wr_block_r      <= 1'b0;
			prog_refused_r  <= 1'b0;
		end else begin
			stack_reset_r   <= stk_nxt;
			bor_active_r    <= bor_nxt;
			bor_level_low_r <= sup_r[SMCD_B_BORLVL];
			lp_bor_en_r     <= !sup_r[SMCD_B_LPBOR];
			wdt_en_r        <= (wdt_f == SMCD_WDT_ON);
			power_up_delay_timer_en_r       <= !sup_r[SMCD_B_POWER_UP_DELAY_TIMER];
			pin_is_reset_r  <= pin_nxt;
			lvp_allowed_r   <= lvp_on;
			debug_active_r  <= !sup_r[SMCD_B_DEBUG];
			wr_grant_r      <= gnt_nxt;
			wr_block_r      <= blk_nxt;
			prog_refused_r  <= lvp_clear;
		end
	end

	// ****************************************
	// register bus
	// ****************************************
	// control: bit0 software brown-out, bit1 lock request, [15:8] unlock key
	wire aw_ok  = aw_hold_r || s_axi_awvalid;
	wire w_ok   = w_hold_r || s_axi_wvalid;
	wire [7:0]  wa  = aw_hold_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wd  = w_hold_r ? w_data_r : s_axi_wdata;
	wire [3:0]  ws  = w_hold_r ? w_strb_r : s_axi_wstrb;
	wire do_wr  = aw_ok && w_ok && !s_axi_bvalid;
	wire wr_ctl = do_wr && (wa == SMCD_OFF_CTRL);
	wire wr_hit = (wa == SMCD_OFF_CTRL) || (wa == SMCD_OFF_SUP) ||
		(wa == SMCD_OFF_MEM) || (wa == SMCD_OFF_STATUS);
	wire key_wr = wr_ctl && ws[1];
	wire lock_wr = wr_ctl && ws[0];
	wire want_lock = wd[1];
	wire seq_done = (unlock_st_r == 2'h2);
	wire lock_chg = lock_wr && seq_done && (want_lock != pin_map_locked_r) &&
		!(sup_r[SMCD_B_ONEWAY] && lock_used_r);
	wire [1:0] unl_nxt = key_wr && (wd[15:8] == SMCD_UNLOCK_1) ? 2'h1
		: key_wr && (wd[15:8] == SMCD_UNLOCK_2) && (unlock_st_r == 2'h1) ? 2'h2
		: lock_wr ? 2'h0 : unlock_st_r;
	wire [7:0] ra = s_axi_araddr;
	wire [31:0] rd_val = (ra == SMCD_OFF_SUP) ? {18'h0, sup_r}
		: (ra == SMCD_OFF_MEM) ? {18'h0, mem_r}
		: (ra == SMCD_OFF_CTRL) ? {30'h0, pin_map_locked_r, sw_bor_r}
		: {27'h0, lock_used_r, bor_active_r, wdt_en_r, pin_is_reset_r, debug_active_r};
	wire rd_hit = (ra == SMCD_OFF_SUP) || (ra == SMCD_OFF_MEM) ||
		(ra == SMCD_OFF_CTRL) || (ra == SMCD_OFF_STATUS);
	wire do_rd = s_axi_arvalid && !s_axi_rvalid;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= SMCD_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= SMCD_RESP_OKAY;
			sw_bor_r      <= 1'b1;
			pin_map_locked_r <= 1'b0;
			lock_used_r   <= 1'b0;
			unlock_st_r   <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready && !do_wr) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_hold_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready && !do_wr) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_wr) begin
				w_hold_r <= 1'b0;
			end
			s_axi_awready <= !(do_wr || aw_hold_r || (s_axi_awvalid && s_axi_awready)) ||
				(s_axi_bvalid && s_axi_bready);
			s_axi_wready  <= !(do_wr || w_hold_r || (s_axi_wvalid && s_axi_wready)) ||
				(s_axi_bvalid && s_axi_bready);
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? SMCD_RESP_OKAY : SMCD_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (lock_wr) begin
				sw_bor_r <= wd[0];
			end
			unlock_st_r <= unl_nxt;
			if (lock_chg) begin
				pin_map_locked_r <= want_lock;
				lock_used_r <= lock_used_r || want_lock;
			end
			if (do_rd) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_arready <= 1'b0;
				s_axi_rdata   <= rd_hit ? rd_val : 32'h0000_0000;
				s_axi_rresp   <= rd_hit ? SMCD_RESP_OKAY : SMCD_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	stack_reset_a: assert property ((stack_push && stack_ptr == SMCD_STACK_FULL
		&& sup_r[SMCD_B_STKRST]) |=> stack_reset_r) else $error("no stack reset");
	stack_quiet_a: assert property (!sup_r[SMCD_B_STKRST] && $stable(sup_r)
		|=> !stack_reset_r) else $error("stray stack reset");
	oneway_lock_a: assert property ((sup_r[SMCD_B_ONEWAY] && lock_used_r &&
		pin_map_locked_r) |=> pin_map_locked_r) else $error("lock reopened");
	bor_on_a: assert property ((bor_f == SMCD_BOR_ON) && $stable(sup_r)
		|=> bor_active_r) else $error("bor not on");
	bor_sleep_a: assert property ((bor_f == SMCD_BOR_SLEEP) && core_sleep && $stable(sup_r)
		|=> !bor_active_r) else $error("bor on in sleep");
	bor_off_a: assert property ((bor_f == 2'h0) && $stable(sup_r)
		|=> !bor_active_r) else $error("bor not off");
	pin_lvp_a: assert property (lvp_on && $stable(mem_r)
		|=> pin_is_reset_r) else $error("pin not reset");
	boot_block_a: assert property ((self_wr_req && wrt_f == SMCD_WRT_BOOT && wr_addr
		<= SMCD_BOOT_TOP && $stable(mem_r)) |=> wr_block_r && !wr_grant_r)
		else $error("boot write let through");
	ext_write_a: assert property (ext_wr_req |=> wr_grant_r)
		else $error("external write blocked");
	lvp_keep_a: assert property (lvp_clear |=> mem_r[SMCD_B_LVP] && prog_refused_r)
		else $error("lvp bit cleared");
	impl_ones_a: assert property ((sup_r | SMCD_SUP_IMPL) == 14'h3FFF &&
		(mem_r | SMCD_MEM_IMPL) == 14'h3FFF) else $error("unimplemented bit low");

	// ****************************************
	// decoded levels
	// ****************************************
	// the past reset term skips the edge after release, where levels still show reset values
	// the stable terms skip the edge after a programming write, where the old word still shows
	bor_level_a: assert property ($past(rst_b) && $stable(sup_r)
		|-> bor_level_low_r == sup_r[SMCD_B_BORLVL])
		else $error("wrong brown-out level");
	lp_bor_a: assert property ($past(rst_b) && $stable(sup_r)
		|-> lp_bor_en_r != sup_r[SMCD_B_LPBOR])
		else $error("wrong low-power brown-out enable");
	wdt_on_a: assert property ($past(rst_b) && $stable(sup_r) && wdt_f == SMCD_WDT_ON
		|-> wdt_en_r)
		else $error("watchdog not on");
	power_up_delay_timer_on_a: assert property ($past(rst_b) && $stable(sup_r)
		|-> power_up_delay_timer_en_r != sup_r[SMCD_B_POWER_UP_DELAY_TIMER])
		else $error("wrong power-up timer enable");
	pin_port_a: assert property ($past(rst_b) && $stable(sup_r) && $stable(mem_r)
		&& !lvp_on |-> pin_is_reset_r == sup_r[SMCD_B_RSTPIN])
		else $error("wrong shared pin function");
	lvp_allow_a: assert property ($past(rst_b) && $stable(mem_r)
		|-> lvp_allowed_r == lvp_on)
		else $error("wrong low-voltage entry permit");
	debug_pins_a: assert property ($past(rst_b) && $stable(sup_r)
		|-> debug_active_r != sup_r[SMCD_B_DEBUG])
		else $error("wrong debugger pin claim");
	bor_awake_a: assert property ((bor_f == SMCD_BOR_SLEEP) && !core_sleep
		|=> bor_active_r)
		else $error("bor off while awake");
	bor_sw_a: assert property ((bor_f == SMCD_BOR_SW)
		|=> bor_active_r == $past(sw_bor_r))
		else $error("bor not following software enable");
	stack_under_a: assert property ((stack_pop && stack_ptr == SMCD_STACK_EMPTY
		&& sup_r[SMCD_B_STKRST]) |=> stack_reset_r)
		else $error("no underflow reset");

	// ****************************************
	// write protection and programming
	// ****************************************
	open_write_a: assert property (self_wr_req && wrt_f == SMCD_WRT_OFF
		|=> wr_grant_r && !wr_block_r)
		else $error("open write blocked");
	boot_open_a: assert property (self_wr_req && wrt_f == SMCD_WRT_BOOT
		&& wr_addr > SMCD_BOOT_TOP |=> wr_grant_r)
		else $error("upper write blocked");
	half_block_a: assert property (self_wr_req && wrt_f == SMCD_WRT_HALF
		&& wr_addr <= SMCD_HALF_TOP |=> wr_block_r)
		else $error("lower half write let through");
	half_open_a: assert property (self_wr_req && wrt_f == SMCD_WRT_HALF
		&& wr_addr > SMCD_HALF_TOP |=> wr_grant_r)
		else $error("upper half write blocked");
	all_block_a: assert property (self_wr_req && wrt_f == 2'h0
		|=> wr_block_r)
		else $error("write let through");
	prog_sup_a: assert property (prog_sup
		|=> sup_r == ($past(prog_data) | ~SMCD_SUP_IMPL))
		else $error("supervisor word not programmed");
	prog_mem_a: assert property (prog_mem && !lvp_clear
		|=> mem_r == ($past(prog_data) | ~SMCD_MEM_IMPL))
		else $error("memory word not programmed");
	lvp_free_a: assert property (prog_mem && !lvp_entry
		|=> !prog_refused_r)
		else $error("programming refused");
	sup_hold_a: assert property (!prog_sup
		|=> $stable(sup_r))
		else $error("supervisor word moved");
	mem_hold_a: assert property (!prog_mem
		|=> $stable(mem_r))
		else $error("memory word moved");
	lock_key_a: assert property (!seq_done
		|=> $stable(pin_map_locked_r))
		else $error("lock changed without key");
	oneway_frozen_a: assert property (sup_r[SMCD_B_ONEWAY] && lock_used_r
		|=> $stable(pin_map_locked_r))
		else $error("one-way lock changed");

	wr_cover_c: cover property (s_axi_bvalid && s_axi_bready);
	rd_cover_c: cover property (s_axi_rvalid && s_axi_rready);
	lock_cover_c: cover property (lock_chg && want_lock);
	stack_cover_c: cover property (stack_reset_r);
	sleep_cover_c: cover property ((bor_f == SMCD_BOR_SLEEP) && core_sleep);
endmodule // smcd_top

// *** test/smcd_tb.sv ***
// Purpose: self-checking bench for the configuration word decoder
// Assumes: registered bus answers and one-edge pulse latency of the decoder
// Notes:   each pulse is taken one edge after its request and must be gone after it
`timescale 1ns/1ps
module testbench;
	import smcd_pkg::*;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [13:0] nvm_sup_word = 14'h3FFF;
	logic [13:0] nvm_mem_word = 14'h3FFF;
	logic        core_sleep = 1'b0;
	logic        lvp_entry = 1'b0;
	logic [4:0]  req = 5'h00;
	logic [15:0] addr = 16'h0000;
	logic [13:0] pdata = 14'h0000;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         srst, bor, lvl, lpb, wdt, power_up_delay_timer, pinr, lvpa, dbg, lock, grant, block, refd;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [3:0]  seen;
	logic [31:0] rd;
	// field, external, grant expected, address
	logic [17:0] wp [7] = '{{4'hD, 14'h3FFF}, {4'h8, 14'h01FF}, {4'h9, 14'h0200},
		{4'h4, 14'h1FFF}, {4'h5, 14'h2000}, {4'h0, 14'h3FFF}, {4'h3, 14'h0000}};
	logic [13:0] sups [4] = '{14'h3FFF, 14'h0000, 14'h2A4C, 14'h15B3};
	logic [13:0] mems [4] = '{14'h3FFF, 14'h0000, 14'h2002, 14'h0001};

	always #5 clock = ~clock;

	smcd_top i_dut (.clock(clock), .rst_b(rst_b), .nvm_sup_word(nvm_sup_word),
		.nvm_mem_word(nvm_mem_word), .core_sleep(core_sleep), .stack_push(req[0]),
		.stack_pop(req[1]), .stack_ptr(addr[4:0]), .self_wr_req(req[2]), .ext_wr_req(req[3]),
		.wr_addr(addr[13:0]), .lvp_entry(lvp_entry), .prog_wr_req(req[4]), .prog_addr(addr),
		.prog_data(pdata), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.stack_reset_r(srst), .bor_active_r(bor), .bor_level_low_r(lvl), .lp_bor_en_r(lpb),
		.wdt_en_r(wdt), .power_up_delay_timer_en_r(power_up_delay_timer), .pin_is_reset_r(pinr), .lvp_allowed_r(lvpa),
		.debug_active_r(dbg), .pin_map_locked_r(lock), .wr_grant_r(grant),
		.wr_block_r(block), .prog_refused_r(refd));

	// ****************************************
	// bus, request and checking tasks
	// ****************************************
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard: the whole sequence needs well under 5000 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	task automatic axw(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axr(logic [7:0] a, logic [1:0] er, output logic [31:0] d);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		chk("rresp", {30'h0, rresp}, {30'h0, er});
	endtask

	// words are only taken while reset is low, so each setting needs a fresh reset
	task automatic cfg(logic [13:0] s, logic [13:0] m);
		@(posedge clock);
		rst_b <= 1'b0;
		nvm_sup_word <= s;
		nvm_mem_word <= m;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic fire(logic [4:0] r, logic [15:0] a, logic [13:0] d);
		@(posedge clock);
		req <= r;
		addr <= a;
		pdata <= d;
		@(posedge clock);
		req <= 5'h00;
		@(negedge clock);
		seen = {refd, block, grant, srst};
		repeat (2) begin
			@(negedge clock);
			chk("pulse end", {28'h0, refd, block, grant, srst}, 32'h0);
		end
	endtask

	task automatic lockw(logic v);
		axw(SMCD_OFF_CTRL, {16'h0, SMCD_UNLOCK_1, 8'h00}, 4'h2, SMCD_RESP_OKAY);
		axw(SMCD_OFF_CTRL, {16'h0, SMCD_UNLOCK_2, 8'h00}, 4'h2, SMCD_RESP_OKAY);
		axw(SMCD_OFF_CTRL, {30'h0, v, 1'b1}, 4'h1, SMCD_RESP_OKAY);
		repeat (2) @(negedge clock);
	endtask

	task automatic levels(logic [13:0] s, logic [13:0] m);
		chk("levels", {25'h0, lvl, lpb, wdt, power_up_delay_timer, pinr, lvpa, dbg}, {25'h0, s[9], ~s[5],
			s[3:2] == SMCD_WDT_ON, ~s[1], m[13] | s[0], m[13], ~s[13]});
		axr(SMCD_OFF_SUP, SMCD_RESP_OKAY, rd);
		chk("sup word", rd, {18'h0, s | ~SMCD_SUP_IMPL});
		axr(SMCD_OFF_MEM, SMCD_RESP_OKAY, rd);
		chk("mem word", rd, {18'h0, m | ~SMCD_MEM_IMPL});
		axr(SMCD_OFF_STATUS, SMCD_RESP_OKAY, rd);
		chk("status", rd & 32'h1F, {28'h0, s[7:6] != 2'h0, s[3:2] == SMCD_WDT_ON,
			m[13] | s[0], ~s[13]});
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		for (int i = 0; i < 4; i++) begin
			cfg(sups[i], mems[i]);
			levels(sups[i], mems[i]);
		end
		// the stored supervisor word changes while running; the decoded copy must not follow
		@(posedge clock);
		nvm_sup_word <= 14'h0000;
		axw(8'h20, 32'h0, 4'hF, SMCD_RESP_SLVERR);
		axr(8'h20, SMCD_RESP_SLVERR, rd);
		chk("unmapped read", rd, 32'h0);
		axw(SMCD_OFF_SUP, 32'h0, 4'hF, SMCD_RESP_OKAY);
		axr(SMCD_OFF_SUP, SMCD_RESP_OKAY, rd);
		chk("held word", rd, {18'h0, 14'h15B3 | ~SMCD_SUP_IMPL});
		for (int f = 0; f < 4; f++) begin
			cfg({6'h3F, f[1:0], 6'h3F}, 14'h3FFF);
			for (int sw = 0; sw < 2; sw++) begin
				axw(SMCD_OFF_CTRL, {31'h0, sw[0]}, 4'h1, SMCD_RESP_OKAY);
				for (int sl = 0; sl < 2; sl++) begin
					@(posedge clock);
					core_sleep <= sl[0];
					repeat (3) @(negedge clock);
					chk("bor", {31'h0, bor}, {31'h0, f == 3 || (f == 2 && sl == 0) ||
						(f == 1 && sw == 1)});
				end
			end
			@(posedge clock);
			core_sleep <= 1'b0;
		end
		for (int ow = 1; ow >= 0; ow--) begin
			cfg({2'h3, ow[0], 11'h7FF}, 14'h3FFF);
			axw(SMCD_OFF_CTRL, 32'h3, 4'h1, SMCD_RESP_OKAY);
			repeat (2) @(negedge clock);
			chk("lock no key", {31'h0, lock}, 32'h0);
			lockw(1'b1);
			chk("lock set", {31'h0, lock}, 32'h1);
			lockw(1'b0);
			chk("lock clear", {31'h0, lock}, {31'h0, ow[0]});
			lockw(1'b1);
			chk("lock again", {31'h0, lock}, 32'h1);
		end
		for (int en = 0; en < 2; en++) begin
			cfg({1'b1, en[0], 12'hFFF}, 14'h3FFF);
			fire(5'h01, {11'h0, SMCD_STACK_FULL}, 14'h0);
			chk("overflow", {31'h0, seen[0]}, {31'h0, en[0]});
			fire(5'h01, 16'h000E, 14'h0);
			chk("push", {31'h0, seen[0]}, 32'h0);
			fire(5'h02, {11'h0, SMCD_STACK_EMPTY}, 14'h0);
			chk("underflow", {31'h0, seen[0]}, {31'h0, en[0]});
		end
		for (int i = 0; i < 7; i++) begin
			cfg(14'h3FFF, {12'hFFF, wp[i][17:16]});
			fire(wp[i][15] ? 5'h08 : 5'h04, {2'h0, wp[i][13:0]}, 14'h0);
			chk("write", {30'h0, seen[2:1]}, {30'h0, ~wp[i][14], wp[i][14]});
		end
		cfg(14'h3FFF, 14'h3FFF);
		@(posedge clock);
		lvp_entry <= 1'b1;
		fire(5'h10, SMCD_MEM_WORD_ADDR, 14'h0001);
		chk("lvp refused", {31'h0, seen[3]}, 32'h1);
		axr(SMCD_OFF_MEM, SMCD_RESP_OKAY, rd);
		chk("lvp kept", rd, 32'h3FFD);
		@(posedge clock);
		lvp_entry <= 1'b0;
		fire(5'h10, SMCD_MEM_WORD_ADDR, 14'h0001);
		chk("lvp cleared", {31'h0, seen[3]}, 32'h0);
		axr(SMCD_OFF_MEM, SMCD_RESP_OKAY, rd);
		chk("mem word", rd, 32'h1FFD);
		fire(5'h10, SMCD_SUP_WORD_ADDR, 14'h0000);
		axr(SMCD_OFF_SUP, SMCD_RESP_OKAY, rd);
		chk("sup word", rd, {18'h0, ~SMCD_SUP_IMPL});
		chk("debug", {31'h0, dbg}, 32'h1);
		close_out();
	end
endmodule // testbench
